// ==== hdl/rbp_ctrl.sv ====
// Reset, brown-out, interrupt poll and power-mode controller.
// Assumes asynchronous pins from the board, AXI4-Lite software access.
// Functional notes
// - After system reset the core restarts fetching at address 0000H.
// - During reset address latch and program store strobes are driven high; a soft reset in power-down leaves them low.
// - System reset keeps RAM, returns every control register to reset value.
// - Power-on sets the power-on flag until software clears it.
// - Soft-reset bit rising resets all but itself, watchdog status, RAM.
// - Brown-out acts only after four consecutive low-supply clocks.
// - Brown-out without its interrupt enable resets core to 0000H.
// - Brown-out with enable set raises interrupt at 004BH, core keeps running.
// - Clearing brown-out enable while condition active resets the device.
// - Four priority levels, each source has enable and two priority bits.
// - Same level polled in fixed order, external 0 first, timer 2 last.
// - Serial port and serial interface share one request at 0023H.
// - Idle halts program counter; clock, interrupts, peripherals keep running.
// - Starting any interrupt service in idle clears idle bit.
// - Hardware reset in idle or power-down restarts like power-on.
// - Power-down stops clock, keeps RAM; only level external interrupts live.
// - Only level external interrupts wake power-down and clear its bit.
// - Wake pin low at least 1024 clocks, service starts once high.
// - Strobes high during idle, low during power-down.
//
// Our own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
module rbp_ctrl (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic power_good,
  input wire logic reset_pin,
  input wire logic brownout_low,
  input wire logic osc_valid,
  input wire logic [3:0] ext_irq_n,
  input wire logic [3:0] ext_level_mode,
  input wire logic [9:0] periph_req,
  input wire logic serial_tx_flag,
  input wire logic serial_rx_flag,
  input wire logic serial_transfer_done_flag,
  input wire logic irq_return,
  output rbp_pkg::rbp_core_ctl_t core_ctl,
  output rbp_pkg::rbp_irq_req_t irq_req,
  output logic [15:0] restart_vector
);
  // ---
  // Pin synchronisers
  // ---
  // Three stages; a change counts once stages two and three agree
  logic [2:0] rst_sync_r, bo_sync_r, osc_sync_r;
  logic [2:0] ext_sync_r [4];
  logic rst_pin_r, bo_pin_r, osc_ok_r;
  logic [3:0] ext_low_r;
  always_ff @(posedge aclk) begin
    rst_sync_r <= {rst_sync_r[1:0], reset_pin};
    bo_sync_r <= {bo_sync_r[1:0], brownout_low};
    osc_sync_r <= {osc_sync_r[1:0], osc_valid};
    for (int i = 0; i < 4; i++) begin
      ext_sync_r[i] <= {ext_sync_r[i][1:0], ~ext_irq_n[i]};
    end
  end
  always_ff @(posedge aclk) begin
    if (rst_sync_r[1] == rst_sync_r[2]) rst_pin_r <= rst_sync_r[2];
    if (bo_sync_r[1] == bo_sync_r[2]) bo_pin_r <= bo_sync_r[2];
    if (osc_sync_r[1] == osc_sync_r[2]) osc_ok_r <= osc_sync_r[2];
    for (int i = 0; i < 4; i++) begin
      if (ext_sync_r[i][1] == ext_sync_r[i][2]) ext_low_r[i] <= ext_sync_r[i][2];
    end
  end

  // ---
  // Hardware reset and brown-out filter
  // ---
  logic [4:0] rst_cnt_r;
  logic hw_reset_r;
  logic [2:0] bo_cnt_r;
  logic bo_active_r;
  always_ff @(posedge aclk) begin
    if (!aresetn || !rst_pin_r) begin
      rst_cnt_r <= '0;
      hw_reset_r <= 1'b0;
    end else if (rst_cnt_r != 5'(rbp_pkg::RST_MIN_CLOCKS - 1)) begin
      rst_cnt_r <= rst_cnt_r + 5'd1;
    end else begin
      hw_reset_r <= 1'b1;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn || !bo_pin_r) begin
      bo_cnt_r <= '0;
      bo_active_r <= 1'b0;
    end else if (bo_cnt_r != 3'(rbp_pkg::BO_FILTER_CLOCKS - 1)) begin
      bo_cnt_r <= bo_cnt_r + 3'd1;
    end else begin
      bo_active_r <= 1'b1;
    end
  end

  // ---
  // Registers
  // ---
  logic [7:0] aux_interrupt_enable_r, power_control_reg_r, flash_config_reg_r;
  logic [7:0] watchdog_control_reg_r, irq_en_r, prio_lo_r, prio_hi_r;
  logic [3:0] ext_prio_lo_r, ext_prio_hi_r;
  logic sys_reset, soft_reset, bo_reset, bo_clear_reset;
  logic wr_fire;
  logic [7:0] wr_addr_r;
  logic [31:0] wr_data_r;
  logic aw_held_r, w_held_r;
  rbp_pkg::rbp_state_t state_r, state_nxt;
  logic power_on_flag_r;
  logic svc_start;

  assign soft_reset = wr_fire && wr_addr_r == rbp_pkg::OFF_FLASH_CFG
    && wr_data_r[rbp_pkg::BIT_SOFT_RST] && !flash_config_reg_r[rbp_pkg::BIT_SOFT_RST];
  assign bo_clear_reset = bo_active_r && wr_fire && wr_addr_r == rbp_pkg::OFF_AUX_IRQ_EN
    && !wr_data_r[rbp_pkg::BIT_BO_IRQ_EN];
  assign bo_reset = bo_active_r && !aux_interrupt_enable_r[rbp_pkg::BIT_BO_IRQ_EN];
  // hardware reset restarts from any mode
  assign sys_reset = hw_reset_r || bo_reset || bo_clear_reset;

  // power-on flag, set wins over clear
  always_ff @(posedge aclk) begin
    if (!power_good) begin
      power_on_flag_r <= 1'b1;
    end else if (wr_fire && wr_addr_r == rbp_pkg::OFF_PWR_CTRL
                 && !wr_data_r[rbp_pkg::BIT_POF]) begin
      power_on_flag_r <= 1'b0;
    end
  end

  // aux enable, power-control, irq enable and low-byte priority registers back to reset value
  always_ff @(posedge aclk) begin
    if (!aresetn || sys_reset || soft_reset) begin
      aux_interrupt_enable_r <= rbp_pkg::RST_REG;
      power_control_reg_r <= rbp_pkg::RST_REG;
      irq_en_r <= rbp_pkg::RST_REG;
      prio_lo_r <= rbp_pkg::RST_REG;
      prio_hi_r <= rbp_pkg::RST_REG;
    end else begin
      if (wr_fire) begin
        case (wr_addr_r)
          rbp_pkg::OFF_AUX_IRQ_EN: aux_interrupt_enable_r <= wr_data_r[7:0];
          rbp_pkg::OFF_PWR_CTRL: power_control_reg_r <= wr_data_r[7:0];
          rbp_pkg::OFF_IRQ_EN: irq_en_r <= wr_data_r[7:0];
          rbp_pkg::OFF_PRIO_LO: prio_lo_r <= wr_data_r[7:0];
          rbp_pkg::OFF_PRIO_HI: prio_hi_r <= wr_data_r[7:0];
          default: ;
        endcase
      end
      // service start clears idle and power-down bits
      if (svc_start) begin
        power_control_reg_r[rbp_pkg::BIT_IDLE] <= 1'b0;
        power_control_reg_r[rbp_pkg::BIT_PDOWN] <= 1'b0;
      end
    end
  end
  // soft-reset bit and watchdog status survive soft reset
  always_ff @(posedge aclk) begin
    if (!aresetn || sys_reset) begin
      flash_config_reg_r <= rbp_pkg::RST_REG;
      watchdog_control_reg_r <= rbp_pkg::RST_REG;
      ext_prio_lo_r <= '0;
      ext_prio_hi_r <= '0;
    end else if (soft_reset) begin
      flash_config_reg_r <= rbp_pkg::RST_REG;
      flash_config_reg_r[rbp_pkg::BIT_SOFT_RST] <= 1'b1;
      watchdog_control_reg_r <= rbp_pkg::RST_REG;
      watchdog_control_reg_r[rbp_pkg::BIT_WDT_STAT] <=
        watchdog_control_reg_r[rbp_pkg::BIT_WDT_STAT];
      ext_prio_lo_r <= '0;
      ext_prio_hi_r <= '0;
    end else if (wr_fire) begin
      case (wr_addr_r)
        rbp_pkg::OFF_FLASH_CFG: flash_config_reg_r <= wr_data_r[7:0];
        rbp_pkg::OFF_WDT_CTRL: watchdog_control_reg_r <= wr_data_r[7:0];
        rbp_pkg::OFF_PRIO_LO: ext_prio_lo_r <= wr_data_r[11:8];
        rbp_pkg::OFF_PRIO_HI: ext_prio_hi_r <= wr_data_r[11:8];
        default: ;
      endcase
    end
  end

  // ---
  // Interrupt poll
  // ---
  // Source index in polling order; enables/priorities are per-source fields
  logic [9:0] pend, en_vec, plo_vec, phi_vec;
  logic [1:0] cur_level_r;
  logic in_service_r;
  rbp_pkg::rbp_irq_req_t pick;
  function automatic logic [15:0] src_vector(input logic [3:0] s);
    case (s)
      4'd0: src_vector = 16'h0003;
      4'd1: src_vector = 16'h004b;
      4'd2: src_vector = 16'h000b;
      4'd3: src_vector = 16'h0013;
      4'd4: src_vector = 16'h001b;
      4'd5: src_vector = 16'h0033;
      4'd6: src_vector = 16'h003b;
      4'd7: src_vector = 16'h0043;
      4'd8: src_vector = 16'h0023;
      default: src_vector = 16'h002b;
    endcase
  endfunction : src_vector
  always_comb begin
    pend = periph_req;
    pend[0] = periph_req[0] | ext_low_r[0];
    pend[3] = periph_req[3] | ext_low_r[1];
    pend[6] = periph_req[6] | ext_low_r[2];
    pend[7] = periph_req[7] | ext_low_r[3];
    pend[1] = bo_active_r;
    pend[8] = serial_tx_flag | serial_rx_flag | serial_transfer_done_flag;
    // power-down keeps only level external sources
    if (state_r == rbp_pkg::ST_PDOWN || state_r == rbp_pkg::ST_WAKE) begin
      pend = {2'b00, ext_level_mode[3] & ext_low_r[3], ext_level_mode[2] & ext_low_r[2],
        2'b00, ext_level_mode[1] & ext_low_r[1], 2'b00, ext_level_mode[0] & ext_low_r[0]};
    end
    en_vec = {irq_en_r[5], irq_en_r[4], aux_interrupt_enable_r[1:0], irq_en_r[6],
      irq_en_r[3], irq_en_r[2], irq_en_r[1], aux_interrupt_enable_r[rbp_pkg::BIT_BO_IRQ_EN],
      irq_en_r[0]};
    plo_vec = {prio_lo_r[5], prio_lo_r[4], ext_prio_lo_r[3:2], prio_lo_r[6],
      prio_lo_r[3], prio_lo_r[2], prio_lo_r[1], ext_prio_lo_r[0], prio_lo_r[0]};
    phi_vec = {prio_hi_r[5], prio_hi_r[4], ext_prio_hi_r[3:2], prio_hi_r[6],
      prio_hi_r[3], prio_hi_r[2], prio_hi_r[1], ext_prio_hi_r[0], prio_hi_r[0]};
    pick = '0;
    // four levels, highest first; fixed order inside a level
    // Last hit wins: highest level, then lowest poll index
    for (int lv = 0; lv < 4; lv++) begin
      for (int s = rbp_pkg::NUM_SRC - 1; s >= 0; s--) begin
        if (pend[s] && en_vec[s] && irq_en_r[7] && {phi_vec[s], plo_vec[s]} == 2'(lv)
            && (!in_service_r || 2'(lv) > cur_level_r)) begin
          pick.source = 4'(s);
          pick.valid = 1'b1;
        end
      end
    end
    pick.vector = src_vector(pick.source);
  end

  // ---
  // Power-mode sequencer
  // ---
  logic [10:0] wake_cnt_r;
  logic wake_done_r;
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      rbp_pkg::ST_RUN: begin
        if (power_control_reg_r[rbp_pkg::BIT_PDOWN]) state_nxt = rbp_pkg::ST_PDOWN;
        else if (power_control_reg_r[rbp_pkg::BIT_IDLE]) state_nxt = rbp_pkg::ST_IDLE;
      end
      rbp_pkg::ST_IDLE: if (pick.valid) state_nxt = rbp_pkg::ST_RUN;
      rbp_pkg::ST_PDOWN: if (pick.valid) state_nxt = rbp_pkg::ST_WAKE;
      // service once pin high after full count, else sleep again
      rbp_pkg::ST_WAKE: if (!(|ext_low_r)) begin
        state_nxt = wake_done_r ? rbp_pkg::ST_RUN : rbp_pkg::ST_PDOWN;
      end
      default: state_nxt = rbp_pkg::ST_RUN;
    endcase
  end
  always_ff @(posedge aclk) begin
    if (!aresetn || sys_reset || soft_reset) state_r <= rbp_pkg::ST_RUN;
    else state_r <= state_nxt;
  end
  // count from valid oscillator, restart on early rise
  always_ff @(posedge aclk) begin
    if (!aresetn || state_r != rbp_pkg::ST_WAKE || !osc_ok_r) begin
      wake_cnt_r <= '0;
      wake_done_r <= 1'b0;
    end else if (!wake_done_r && !(|ext_low_r)) begin
      wake_cnt_r <= '0;
    end else if (wake_cnt_r != 11'(rbp_pkg::PD_EXIT_CLOCKS - 1)) begin
      wake_cnt_r <= wake_cnt_r + 11'd1;
    end else begin
      wake_done_r <= 1'b1;
    end
  end
  assign svc_start = (state_r == rbp_pkg::ST_IDLE && pick.valid)
    || (state_r == rbp_pkg::ST_WAKE && state_nxt == rbp_pkg::ST_RUN)
    || (state_r == rbp_pkg::ST_RUN && pick.valid && !in_service_r);
  // Waking pin is high again at service start, so keep its request
  rbp_pkg::rbp_irq_req_t wake_pick_r, svc_pick;
  always_ff @(posedge aclk) begin
    if (state_r == rbp_pkg::ST_PDOWN) wake_pick_r <= pick;
  end
  assign svc_pick = state_r == rbp_pkg::ST_WAKE ? wake_pick_r : pick;
  always_ff @(posedge aclk) begin
    if (!aresetn || sys_reset || soft_reset) begin
      in_service_r <= 1'b0;
      cur_level_r <= '0;
      irq_req <= '0;
    end else begin
      irq_req <= '0;
      if (irq_return) in_service_r <= 1'b0;
      if (svc_start && svc_pick.valid) begin
        in_service_r <= 1'b1;
        cur_level_r <= {phi_vec[svc_pick.source], plo_vec[svc_pick.source]};
        irq_req <= svc_pick;
      end
    end
  end
  // restart at reset vector; strobes forced high in system reset only, not soft reset; mode strobes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      core_ctl <= '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1};
      restart_vector <= rbp_pkg::RESET_VECTOR;
    end else begin
      core_ctl.cpu_reset <= sys_reset || soft_reset;
      core_ctl.halt_pc <= state_nxt != rbp_pkg::ST_RUN;
      core_ctl.clock_stop <= state_nxt == rbp_pkg::ST_PDOWN;
      core_ctl.ale <= state_nxt != rbp_pkg::ST_PDOWN || sys_reset;
      core_ctl.program_store_strobe_n <= state_nxt != rbp_pkg::ST_PDOWN || sys_reset;
    end
  end

  // ---
  // AXI4-Lite slave
  // ---
  assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
  assign s_axi_wready = !w_held_r && !s_axi_bvalid;
  assign wr_fire = aw_held_r && w_held_r && !s_axi_bvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      wr_addr_r <= '0;
      wr_data_r <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_r <= 1'b1;
        wr_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_r <= 1'b1;
        // Only lane 0 is checked, even for bits 11:8; without it the power-control value is written
        wr_data_r <= s_axi_wstrb[0] ? s_axi_wdata : {24'h0, power_control_reg_r};
      end
      if (wr_fire) begin
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= addr_ok(wr_addr_r) ? 2'b00 : 2'b10;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  function automatic logic addr_ok(input logic [7:0] a);
    addr_ok = a inside {rbp_pkg::OFF_AUX_IRQ_EN, rbp_pkg::OFF_PWR_CTRL,
      rbp_pkg::OFF_FLASH_CFG, rbp_pkg::OFF_WDT_CTRL, rbp_pkg::OFF_IRQ_EN,
      rbp_pkg::OFF_PRIO_LO, rbp_pkg::OFF_PRIO_HI, rbp_pkg::OFF_STATUS};
  endfunction : addr_ok
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= 2'b00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= addr_ok(s_axi_araddr) ? 2'b00 : 2'b10;
      case (s_axi_araddr)
        rbp_pkg::OFF_AUX_IRQ_EN: s_axi_rdata <= {24'h0, aux_interrupt_enable_r};
        rbp_pkg::OFF_PWR_CTRL: s_axi_rdata <= {24'h0, power_control_reg_r[7:5],
          power_on_flag_r, power_control_reg_r[3:0]};
        rbp_pkg::OFF_FLASH_CFG: s_axi_rdata <= {24'h0, flash_config_reg_r};
        rbp_pkg::OFF_WDT_CTRL: s_axi_rdata <= {24'h0, watchdog_control_reg_r};
        rbp_pkg::OFF_IRQ_EN: s_axi_rdata <= {24'h0, irq_en_r};
        rbp_pkg::OFF_PRIO_LO: s_axi_rdata <= {20'h0, ext_prio_lo_r, prio_lo_r};
        rbp_pkg::OFF_PRIO_HI: s_axi_rdata <= {20'h0, ext_prio_hi_r, prio_hi_r};
        rbp_pkg::OFF_STATUS: s_axi_rdata <= {24'h0, bo_active_r, hw_reset_r,
          in_service_r, wake_done_r, state_r};
        default: s_axi_rdata <= '0;
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule : rbp_ctrl

// ==== hdl/rbp_pkg.sv ====
// Package for the reset, brown-out and power-mode controller.
// Assumes a single 200 MHz clock and an AXI4-Lite register master.
package rbp_pkg;
  // ---
  // Register offsets (byte addresses)
  // ---
  localparam logic [7:0] OFF_AUX_IRQ_EN = 8'he8;
  localparam logic [7:0] OFF_PWR_CTRL = 8'h87;
  localparam logic [7:0] OFF_FLASH_CFG = 8'hb0;
  localparam logic [7:0] OFF_WDT_CTRL = 8'hc0;
  localparam logic [7:0] OFF_IRQ_EN = 8'ha8;
  localparam logic [7:0] OFF_PRIO_LO = 8'hb8;
  localparam logic [7:0] OFF_PRIO_HI = 8'hb4;
  localparam logic [7:0] OFF_STATUS = 8'hc4;
  // ---
  // Field positions
  // ---
  localparam int BIT_IDLE = 0;
  localparam int BIT_PDOWN = 1;
  localparam int BIT_POF = 4;
  localparam int BIT_SOFT_RST = 1;
  localparam int BIT_WDT_STAT = 2;
  localparam int BIT_BO_IRQ_EN = 3;
  // ---
  // Reset values and counts
  // ---
  localparam logic [7:0] RST_REG = 8'h00;
  localparam logic [15:0] RESET_VECTOR = 16'h0000;
  localparam int RST_MIN_CLOCKS = 24;
  localparam int BO_FILTER_CLOCKS = 4;
  localparam int PD_EXIT_CLOCKS = 1024;
  localparam int NUM_SRC = 10;
  // ---
  // Types
  // ---
  typedef enum logic [3:0] {
    ST_RUN = 4'b0001,
    ST_IDLE = 4'b0010,
    ST_PDOWN = 4'b0100,
    ST_WAKE = 4'b1000
  } rbp_state_t;
  typedef struct packed {
    logic [15:0] vector;
    logic [3:0] source;
    logic valid;
  } rbp_irq_req_t;
  typedef struct packed {
    logic cpu_reset;
    logic halt_pc;
    logic clock_stop;
    logic ale;
    logic program_store_strobe_n;
  } rbp_core_ctl_t;
endpackage : rbp_pkg

// ==== tb/rbp_ctrl_sva.sv ====
// Checker for the core control and interrupt outputs of rbp_ctrl.
// Assumes binding onto rbp_ctrl; one clock, sync active-low reset.
`timescale 1ns/10ps
module rbp_ctrl_sva (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic reset_pin,
  input wire logic osc_valid,
  input wire logic brownout_low,
  input wire logic [3:0] ext_irq_n,
  input wire rbp_pkg::rbp_core_ctl_t core_ctl,
  input wire rbp_pkg::rbp_irq_req_t irq_req,
  input wire logic [15:0] restart_vector
);
  localparam logic [15:0] VEC [10] = '{16'h0003, 16'h004b, 16'h000b, 16'h0013, 16'h001b,
    16'h0033, 16'h003b, 16'h0043, 16'h0023, 16'h002b};
  logic [10:0] low_cnt_r;
  logic woke_r;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // ---
  // Helpers
  // ---
  // Early rise restarts the count; a long low holds it
  always_ff @(posedge aclk) begin
    if (!aresetn || !core_ctl.halt_pc) begin
      low_cnt_r <= 11'h000;
    end else if (ext_irq_n == 4'hf && low_cnt_r < 11'h3e8) begin
      low_cnt_r <= 11'h000;
    end else if (ext_irq_n != 4'hf && osc_valid && low_cnt_r != 11'h7ff) begin
      low_cnt_r <= low_cnt_r + 11'h001;
    end
  end
  // Marks a halt that came from a stopped clock
  always_ff @(posedge aclk) begin
    if (!aresetn || !core_ctl.halt_pc) begin
      woke_r <= 1'b0;
    end else if (core_ctl.clock_stop) begin
      woke_r <= 1'b1;
    end
  end
  // ---
  // Properties
  // ---
  property p_rst_strobe; core_ctl.cpu_reset |-> core_ctl.ale && core_ctl.program_store_strobe_n;
  endproperty
  property p_restart; $fell(core_ctl.cpu_reset) |-> restart_vector == 16'h0000 && !core_ctl.halt_pc;
  endproperty
  property p_bo_filter; (!brownout_low) [*8] |=> !(irq_req.valid && irq_req.source == 4'h1);
  endproperty
  property p_vector; irq_req.valid |-> irq_req.source < 4'ha && irq_req.vector == VEC[irq_req.source];
  endproperty
  property p_idle_strobe; core_ctl.halt_pc && !core_ctl.clock_stop && !woke_r && !core_ctl.cpu_reset
    |-> core_ctl.ale && core_ctl.program_store_strobe_n;
  endproperty
  property p_stop_strobe; core_ctl.clock_stop && !core_ctl.cpu_reset
    |-> !core_ctl.ale && !core_ctl.program_store_strobe_n;
  endproperty
  property p_stop_halts; core_ctl.clock_stop |-> core_ctl.halt_pc;
  endproperty
  property p_wake_src; woke_r && irq_req.valid |-> irq_req.source inside {4'h0, 4'h3, 4'h6, 4'h7};
  endproperty
  property p_wake_len; woke_r && irq_req.valid && !reset_pin |-> low_cnt_r >= 11'h3e8;
  endproperty
  a_rst_strobe: assert property (p_rst_strobe) else $error("strobes low in reset");
  a_restart: assert property (p_restart) else $error("bad restart");
  a_bo_filter: assert property (p_bo_filter) else $error("brown-out not filtered");
  a_vector: assert property (p_vector) else $error("wrong vector for source");
  a_idle_strobe: assert property (p_idle_strobe) else $error("strobes low in idle");
  a_stop_strobe: assert property (p_stop_strobe) else $error("strobes high in stop");
  a_stop_halts: assert property (p_stop_halts) else $error("stop without halt");
  a_wake_src: assert property (p_wake_src) else $error("non-level wake");
  a_wake_len: assert property (p_wake_len) else $error("early stop exit");
  c_stop: cover property (core_ctl.clock_stop);
  c_bo: cover property (irq_req.valid && irq_req.source == 4'h1);
  c_rst: cover property (core_ctl.cpu_reset);
endmodule : rbp_ctrl_sva
bind rbp_ctrl rbp_ctrl_sva u_sva (.aclk(aclk), .aresetn(aresetn), .reset_pin(reset_pin),
  .osc_valid(osc_valid), .brownout_low(brownout_low), .ext_irq_n(ext_irq_n),
  .core_ctl(core_ctl), .irq_req(irq_req), .restart_vector(restart_vector));

// ==== tb/rbp_board.sv ====
// Board model: reset circuit and level wake pin with oscillator restart.
// Assumes one-cycle kicks from the bench on the bench clock.
`timescale 1ns/10ps
module rbp_board #(
  parameter int RST_HOLD = 40,
  parameter int OSC_START = 20
) (
  input wire logic aclk,
  input wire logic rst_go,
  input wire logic wake_go,
  input wire logic [11:0] wake_len,
  output logic reset_pin,
  output logic osc_valid,
  output logic ext0_n,
  output logic busy
);
  initial begin
    reset_pin = 1'b0;
    osc_valid = 1'b1;
    ext0_n = 1'b1;
    busy = 1'b0;
    forever begin
      @(posedge aclk);
      if (rst_go) begin
        busy <= 1'b1;
        reset_pin <= 1'b1;
        repeat (RST_HOLD) @(posedge aclk);
        reset_pin <= 1'b0;
        busy <= 1'b0;
      end else if (wake_go) begin
        busy <= 1'b1;
        ext0_n <= 1'b0;
        osc_valid <= 1'b0;
        repeat (OSC_START) @(posedge aclk);
        osc_valid <= 1'b1;
        repeat (wake_len) @(posedge aclk);
        ext0_n <= 1'b1;
        busy <= 1'b0;
      end
    end
  end
endmodule : rbp_board

// ==== tb/reset_brownout_power_modes_tb.sv ====
// Self-checking bench for rbp_ctrl with the board model.
// Assumes the package, design, board model and checker compiled first.
`timescale 1ns/10ps
module reset_brownout_power_modes_tb;
  typedef struct packed {logic [7:0] d; logic [7:0] m; logic [1:0] r;} rbp_rd_t;
  localparam logic [15:0] VEC [5] = '{16'h000b, 16'h001b, 16'h0033, 16'h0023, 16'h002b};
  localparam int IDX [5] = '{2, 4, 5, 8, 9};
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, power_good;
  logic reset_pin, brownout_low, osc_valid, ext0_n, irq_return, rst_go, wake_go, busy;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [9:0] periph_req;
  logic [2:0] ser;
  logic [11:0] wake_len;
  logic [15:0] restart_vector;
  logic [4:0] m;
  rbp_pkg::rbp_core_ctl_t core_ctl;
  rbp_pkg::rbp_irq_req_t irq_req;
  rbp_rd_t e;
  rbp_rd_t rd_q [$];
  logic [15:0] irq_q [$];
  int n_mismatch, compares, cyc, r, i;
  rbp_ctrl uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .power_good, .reset_pin, .brownout_low, .osc_valid, .ext_irq_n({3'h7, ext0_n}),
    .ext_level_mode(4'hf), .periph_req, .serial_tx_flag(ser[0]), .serial_rx_flag(ser[1]),
    .serial_transfer_done_flag(ser[2]), .irq_return, .core_ctl, .irq_req, .restart_vector);
  rbp_board u_board (.aclk, .rst_go, .wake_go, .wake_len, .reset_pin, .osc_valid, .ext0_n, .busy);
  // ---
  // Tasks
  // ---
  task automatic err(input string s);
    $display("Error %0t ns: %s", $time, s);
    n_mismatch++;
  endtask : err
  task automatic chk(input logic g, input logic x);
    @(negedge aclk);
    compares++;
    if (g !== x) err("control output mismatch");
  endtask : chk
  task automatic pause(input int n);
    repeat (n) @(negedge aclk);
  endtask : pause
  task automatic axw(input logic [7:0] a, input logic [7:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    do begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
  endtask : axw
  task automatic axr(input logic [7:0] a, input logic [7:0] d, input logic [7:0] k,
    input logic [1:0] rs);
    @(posedge aclk);
    rd_q.push_back({d, k, rs});
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'b11;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
  endtask : axr
  task automatic set_src(input int k, input logic v);
    if (IDX[k] == 8) ser <= v ? 3'b001 << ($urandom % 3) : 3'b000;
    else periph_req[IDX[k]] <= v;
  endtask : set_src
  task automatic wait_q();
    while (irq_q.size() != 0) @(negedge aclk);
    @(posedge aclk);
    irq_return <= 1'b1;
    @(posedge aclk);
    irq_return <= 1'b0;
  endtask : wait_q
  task automatic wait_rst();
    int k;
    for (k = 0; k < 200 && core_ctl.cpu_reset !== 1'b1; k++) @(negedge aclk);
    compares++;
    if (core_ctl.cpu_reset !== 1'b1) err("no core reset");
  endtask : wait_rst
  task automatic board(input logic rq, input logic [11:0] n);
    @(posedge aclk);
    {rst_go, wake_go} <= {rq, !rq};
    wake_len <= n;
    @(posedge aclk);
    {rst_go, wake_go} <= 2'b00;
  endtask : board
  task automatic summarize();
    $display("Mismatches %0d, compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : summarize
  // ---
  // Monitors and sequence
  // ---
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      err("timeout");
      summarize();
    end
    if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) begin
      compares++;
      e = rd_q.pop_front();
      if ((s_axi_rdata[7:0] & e.m) !== (e.d & e.m) || s_axi_rresp !== e.r) err("read mismatch");
    end
    if (aresetn === 1'b1 && irq_req.valid === 1'b1) begin
      compares++;
      if (irq_q.size() == 0) err("unexpected interrupt");
      else if (irq_req.vector !== irq_q.pop_front()) err("wrong vector");
    end
  end
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {power_good, brownout_low, irq_return, rst_go, wake_go, periph_req, ser} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, wake_len} = '0;
    void'($urandom(32'h4519afe6));
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (4) @(posedge aclk);
    power_good <= 1'b1;
    axr(8'h87, 8'h10, 8'h10, 2'b00);
    axr(8'he8, 8'h00, 8'hff, 2'b00);
    axr(8'h10, 8'h00, 8'hff, 2'b10);
    axw(8'h87, 8'h00);
    axr(8'h87, 8'h00, 8'h10, 2'b00);
    axw(8'ha8, 8'hff);
    for (r = 0; r < 4; r++) begin
      m = 5'h01 + 5'($urandom % 31);
      @(posedge aclk);
      for (i = 0; i < 5; i++) if (m[i]) set_src(i, 1'b1);
      for (i = 0; i < 5; i++) if (m[i]) begin
        irq_q.push_back(VEC[i]);
        while (irq_q.size() != 0) @(negedge aclk);
        @(posedge aclk);
        set_src(i, 1'b0);
        wait_q();
      end
    end
    axw(8'ha8, 8'h85);
    axw(8'hb0, 8'h02);
    pause(4);
    axr(8'ha8, 8'h00, 8'hff, 2'b00);
    axr(8'hb0, 8'h02, 8'h02, 2'b00);
    axw(8'ha8, 8'hff);
    axw(8'h87, 8'h01);
    pause(4);
    chk(core_ctl.halt_pc, 1'b1);
    periph_req[2] <= 1'b1;
    irq_q.push_back(16'h000b);
    while (irq_q.size() != 0) @(negedge aclk);
    periph_req[2] <= 1'b0;
    wait_q();
    axr(8'h87, 8'h00, 8'h01, 2'b00);
    chk(core_ctl.halt_pc, 1'b0);
    axw(8'h87, 8'h01);
    board(1'b1, 12'h000);
    wait_rst();
    pause(60);
    chk(core_ctl.halt_pc, 1'b0);
    axr(8'ha8, 8'h00, 8'hff, 2'b00);
    axw(8'ha8, 8'h81);
    axw(8'h87, 8'h02);
    pause(4);
    chk(core_ctl.clock_stop, 1'b1);
    board(1'b0, 12'h12c);
    pause(340);
    chk(core_ctl.clock_stop, 1'b1);
    irq_q.push_back(16'h0003);
    board(1'b0, 12'h44c);
    pause(1100);
    compares++;
    if (irq_q.size() != 1) err("wake service before pin release");
    wait_q();
    axr(8'h87, 8'h00, 8'h02, 2'b00);
    axw(8'he8, 8'h08);
    brownout_low <= 1'b1;
    repeat (3) @(posedge aclk);
    brownout_low <= 1'b0;
    pause(20);
    irq_q.push_back(16'h004b);
    @(posedge aclk);
    brownout_low <= 1'b1;
    while (irq_q.size() != 0) @(negedge aclk);
    chk(core_ctl.cpu_reset, 1'b0);
    axw(8'he8, 8'h00);
    wait_rst();
    @(posedge aclk);
    brownout_low <= 1'b0;
    pause(10);
    @(posedge aclk);
    brownout_low <= 1'b1;
    wait_rst();
    summarize();
  end
endmodule : reset_brownout_power_modes_tb
